/* rtl/tt_pkg.sv */
// shared constants, register map and field layouts of the second timer's control block
// assumes a 32-bit axi4-lite register bus and one system clock
package tt_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned PRESCALE_W = 7;
  localparam int unsigned EDGE_W = 3;

  localparam logic [ADDR_W-1:0] OFF_FLAGS_ENABLES = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CONFIG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_COMPARE_FIRST = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_COMPARE_SECOND = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE_FIRST = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE_SECOND = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h24;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // flag bits 7,6,4,3,1 and enable bits 5,2,0 of the flags/enables layout
  localparam logic [7:0] FLAG_MASK = 8'hDA;
  localparam logic [7:0] ENABLE_MASK = 8'h25;
  localparam logic [7:0] FLAGS_ENABLES_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;

  localparam int unsigned EDGE_CAPTURE_FIRST = 0;
  localparam int unsigned EDGE_CAPTURE_SECOND = 1;
  localparam int unsigned EDGE_EVENT = 2;

  typedef enum logic [1:0] {
    TT_MODE_SOFTWARE = 2'h0,
    TT_MODE_PWM = 2'h1,
    TT_MODE_CAPTURE = 2'h2,
    TT_MODE_EVENT = 2'h3
  } tt_mode_t;

  typedef struct packed {
    logic capture_flag_second;
    logic capture_flag_first;
    logic capture_irq_enable;
    logic compare_flag_second;
    logic compare_flag_first;
    logic compare_irq_enable;
    logic overflow_flag;
    logic overflow_irq_enable;
  } tt_flags_enables_t;

  typedef struct packed {
    logic pin_read_select;
    logic capture_edge_select;
    logic event_edge_select;
    logic [2:0] prescale_code;
    tt_mode_t timer_mode_code;
  } tt_config_t;

  // low bits that must all be one for a divided tick: divide by 2**code
  function automatic logic [PRESCALE_W-1:0] tt_prescale_mask(input logic [2:0] code);
    logic [PRESCALE_W:0] one_hot;
    one_hot = 8'h01 << code;
    return PRESCALE_W'(one_hot - 8'h01);
  endfunction

endpackage

/* rtl/tt_prescaler.sv */
// free-running divider producing one-cycle timer ticks from the system clock
// assumes a synchronous active-low reset from the top
`timescale 1ns/1ps
module tt_prescaler #(
  parameter int unsigned WIDTH = tt_pkg::PRESCALE_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] code,
  output logic tick
);

  logic [WIDTH-1:0] div_reg;
  logic [WIDTH-1:0] div_next;
  logic [WIDTH-1:0] mask;

  always_comb begin
    mask = WIDTH'(tt_pkg::tt_prescale_mask(code));
    div_next = WIDTH'(div_reg + 1'b1);
    tick = (div_reg & mask) == mask;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

endmodule // tt_prescaler

/* rtl/tt_edge_detect.sv */
// per-bit edge detector with selectable polarity, one-cycle pulse out
// assumes inputs are already synchronous to clk
`timescale 1ns/1ps
module tt_edge_detect #(
  parameter int unsigned WIDTH = tt_pkg::EDGE_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] sample,
  input wire logic [WIDTH-1:0] rising_sel,
  output logic [WIDTH-1:0] edge_pulse
);

  logic [WIDTH-1:0] prev_reg;
  logic primed_reg;

  // no edge is reported until a first sample has been seen after reset
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign edge_pulse[i] = primed_reg &
        (rising_sel[i] ? (sample[i] & ~prev_reg[i]) : (~sample[i] & prev_reg[i]));
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= '0;
      primed_reg <= 1'b0;
    end else begin
      prev_reg <= sample;
      primed_reg <= 1'b1;
    end
  end

endmodule // tt_edge_detect

/* rtl/tt_timer_two.sv */
// second timer control/status block: flags, enables, config, counter and axi4-lite slave
// assumes capture and event pins synchronous to clk; port logic consumes pin_read_select
// Contract
// - capture mode: edge on second capture input sets sticky second capture flag
// - capture mode: edge on first capture input sets sticky first capture flag
// - capture enable gates capture flags onto the interrupt
// - counter equal to active second compare value sets sticky flag
// - counter equal to active first compare value sets sticky flag
// - compare enable gates compare flags onto the interrupt
// - counter wrap from maximum to zero sets sticky overflow flag
// - overflow enable gates overflow flag onto the interrupt
// - port read select chooses pin levels (1) or data register (0)
// - capture edge bit picks rising (1) or falling (0) capture edges
// - event edge bit picks rising (1) or falling (0) event edges
// - prescale code divides system clock by 1 to 128 per counter tick
// - mode code: software, pwm, capture/compare, external event
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module tt_timer_two (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [tt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tt_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [tt_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic capture_input_first,
  input wire logic capture_input_second,
  input wire logic event_count_input,
  output logic pin_read_select,
  output logic irq
);

  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  function automatic logic tt_addr_known(input logic [tt_pkg::ADDR_W-1:0] a);
    return a == tt_pkg::OFF_FLAGS_ENABLES || a == tt_pkg::OFF_CONFIG
      || a == tt_pkg::OFF_COMPARE_FIRST || a == tt_pkg::OFF_COMPARE_SECOND
      || a == tt_pkg::OFF_COUNT || a == tt_pkg::OFF_CAPTURE_FIRST
      || a == tt_pkg::OFF_CAPTURE_SECOND || a == tt_pkg::OFF_IRQ_STATUS
      || a == tt_pkg::OFF_IRQ_CLEAR || a == tt_pkg::OFF_IRQ_ENABLE;
  endfunction

  // timer state
  tt_pkg::tt_flags_enables_t flags_reg, flags_next;
  tt_pkg::tt_config_t config_reg, config_next;
  logic [tt_pkg::COUNT_W-1:0] compare_value_first_reg, compare_value_first_next;
  logic [tt_pkg::COUNT_W-1:0] compare_value_second_reg, compare_value_second_next;
  logic [tt_pkg::COUNT_W-1:0] count_reg, count_next;
  logic [tt_pkg::COUNT_W-1:0] capture_first_reg, capture_first_next;
  logic [tt_pkg::COUNT_W-1:0] capture_second_reg, capture_second_next;
  logic active_second_reg, active_second_next;
  logic irq_reg, irq_next;

  // write channel state
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [tt_pkg::ADDR_W-1:0] waddr_reg, waddr_next;
  logic [tt_pkg::DATA_W-1:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic wr_do;

  // read channel state
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [tt_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  logic tick;
  logic [tt_pkg::EDGE_W-1:0] edge_pulse;
  logic [tt_pkg::EDGE_W-1:0] rising_sel;

  assign rising_sel[tt_pkg::EDGE_CAPTURE_FIRST] = config_reg.capture_edge_select;
  assign rising_sel[tt_pkg::EDGE_CAPTURE_SECOND] = config_reg.capture_edge_select;
  assign rising_sel[tt_pkg::EDGE_EVENT] = config_reg.event_edge_select;

  tt_prescaler #(
    .WIDTH(tt_pkg::PRESCALE_W)
  ) u_prescaler (
    .clk(clk),
    .rst_n(rst_n),
    .code(config_reg.prescale_code),
    .tick(tick)
  );

  tt_edge_detect #(
    .WIDTH(tt_pkg::EDGE_W)
  ) u_edges (
    .clk(clk),
    .rst_n(rst_n),
    .sample({event_count_input, capture_input_second, capture_input_first}),
    .rising_sel(rising_sel),
    .edge_pulse(edge_pulse)
  );

  // axi write channel: address and data taken in either order, response after both
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      waddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (wr_do) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = tt_addr_known(waddr_reg) ? tt_pkg::RESP_OKAY : tt_pkg::RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_held_next && !bvalid_next;
    wready_next = !w_held_next && !bvalid_next;
  end

  // axi read channel: one read at a time, answer one edge after acceptance
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = tt_pkg::RESP_OKAY;
      rdata_next = '0;
      if (s_axi_araddr == tt_pkg::OFF_FLAGS_ENABLES) begin
        rdata_next[7:0] = flags_reg;
      end else if (s_axi_araddr == tt_pkg::OFF_CONFIG) begin
        rdata_next[7:0] = config_reg;
      end else if (s_axi_araddr == tt_pkg::OFF_COMPARE_FIRST) begin
        rdata_next[tt_pkg::COUNT_W-1:0] = compare_value_first_reg;
      end else if (s_axi_araddr == tt_pkg::OFF_COMPARE_SECOND) begin
        rdata_next[tt_pkg::COUNT_W-1:0] = compare_value_second_reg;
      end else if (s_axi_araddr == tt_pkg::OFF_COUNT) begin
        rdata_next[tt_pkg::COUNT_W-1:0] = count_reg;
      end else if (s_axi_araddr == tt_pkg::OFF_CAPTURE_FIRST) begin
        rdata_next[tt_pkg::COUNT_W-1:0] = capture_first_reg;
      end else if (s_axi_araddr == tt_pkg::OFF_CAPTURE_SECOND) begin
        rdata_next[tt_pkg::COUNT_W-1:0] = capture_second_reg;
      end else if (s_axi_araddr == tt_pkg::OFF_IRQ_STATUS) begin
        rdata_next[7:0] = flags_reg & tt_pkg::FLAG_MASK;
      end else if (s_axi_araddr == tt_pkg::OFF_IRQ_ENABLE) begin
        rdata_next[7:0] = flags_reg & tt_pkg::ENABLE_MASK;
      end else if (!tt_addr_known(s_axi_araddr)) begin
        rresp_next = tt_pkg::RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next;
  end

  // timer: software writes first, hardware events afterwards so a set wins
  always_comb begin
    logic [7:0] wd;
    logic [tt_pkg::COUNT_W-1:0] count_plus;
    logic advance, cap_first, cap_second, wrap, hit_first, hit_second;
    wd = wdata_reg[7:0];
    // event mode counts pin edges, every other mode counts prescaled ticks
    advance = (config_reg.timer_mode_code == tt_pkg::TT_MODE_EVENT)
      ? edge_pulse[tt_pkg::EDGE_EVENT] : tick;
    count_plus = tt_pkg::COUNT_W'(count_reg + tt_pkg::COUNT_ONE);
    count_next = advance ? count_plus : count_reg;
    wrap = advance && count_reg == tt_pkg::COUNT_MAX;
    hit_first = advance && !active_second_reg && count_plus == compare_value_first_reg;
    hit_second = advance && active_second_reg && count_plus == compare_value_second_reg;
    cap_first = config_reg.timer_mode_code == tt_pkg::TT_MODE_CAPTURE
      && edge_pulse[tt_pkg::EDGE_CAPTURE_FIRST];
    cap_second = config_reg.timer_mode_code == tt_pkg::TT_MODE_CAPTURE
      && edge_pulse[tt_pkg::EDGE_CAPTURE_SECOND];
    flags_next = flags_reg;
    config_next = config_reg;
    compare_value_first_next = compare_value_first_reg;
    compare_value_second_next = compare_value_second_reg;
    capture_first_next = capture_first_reg;
    capture_second_next = capture_second_reg;
    active_second_next = active_second_reg;
    if (wr_do && wstrb_reg[0]) begin
      if (waddr_reg == tt_pkg::OFF_FLAGS_ENABLES) begin
        flags_next = (wd & tt_pkg::ENABLE_MASK) | (flags_reg & wd & tt_pkg::FLAG_MASK);
      end else if (waddr_reg == tt_pkg::OFF_CONFIG) begin
        config_next = wd;
      end else if (waddr_reg == tt_pkg::OFF_IRQ_CLEAR) begin
        flags_next = flags_reg & ~(wd & tt_pkg::FLAG_MASK);
      end else if (waddr_reg == tt_pkg::OFF_IRQ_ENABLE) begin
        flags_next = (flags_reg & tt_pkg::FLAG_MASK) | (wd & tt_pkg::ENABLE_MASK);
      end
    end
    if (wr_do && waddr_reg == tt_pkg::OFF_COMPARE_FIRST) begin
      if (wstrb_reg[0]) compare_value_first_next[7:0] = wdata_reg[7:0];
      if (wstrb_reg[1]) compare_value_first_next[15:8] = wdata_reg[15:8];
    end
    if (wr_do && waddr_reg == tt_pkg::OFF_COMPARE_SECOND) begin
      if (wstrb_reg[0]) compare_value_second_next[7:0] = wdata_reg[7:0];
      if (wstrb_reg[1]) compare_value_second_next[15:8] = wdata_reg[15:8];
    end
    // a match hands the comparison over to the other compare value
    if (hit_first || hit_second) active_second_next = !active_second_reg;
    if (cap_first) begin
      flags_next.capture_flag_first = 1'b1;
      capture_first_next = count_reg;
    end
    if (cap_second) begin
      flags_next.capture_flag_second = 1'b1;
      capture_second_next = count_reg;
    end
    if (hit_first) flags_next.compare_flag_first = 1'b1;
    if (hit_second) flags_next.compare_flag_second = 1'b1;
    if (wrap) flags_next.overflow_flag = 1'b1;
    irq_next = (flags_next.capture_irq_enable
        && (flags_next.capture_flag_first || flags_next.capture_flag_second))
      || (flags_next.compare_irq_enable
        && (flags_next.compare_flag_first || flags_next.compare_flag_second))
      || (flags_next.overflow_irq_enable && flags_next.overflow_flag);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= tt_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= tt_pkg::RESP_OKAY;
      flags_reg <= tt_pkg::FLAGS_ENABLES_RESET;
      config_reg <= tt_pkg::CONFIG_RESET;
      compare_value_first_reg <= tt_pkg::COUNT_ZERO;
      compare_value_second_reg <= tt_pkg::COUNT_ZERO;
      count_reg <= tt_pkg::COUNT_ZERO;
      capture_first_reg <= tt_pkg::COUNT_ZERO;
      capture_second_reg <= tt_pkg::COUNT_ZERO;
      active_second_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      flags_reg <= flags_next;
      config_reg <= config_next;
      compare_value_first_reg <= compare_value_first_next;
      compare_value_second_reg <= compare_value_second_next;
      count_reg <= count_next;
      capture_first_reg <= capture_first_next;
      capture_second_reg <= capture_second_next;
      active_second_reg <= active_second_next;
      irq_reg <= irq_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign pin_read_select = config_reg.pin_read_select;
  assign irq = irq_reg;

endmodule // tt_timer_two

/* verification/tt_timer_two_sva.sv */
// assertion checker for the second timer control block, bound to its top
// assumes the bench offers write address and write data in one cycle
`timescale 1ns/1ps
module tt_timer_two_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [tt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [tt_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic capture_input_first,
  input wire logic pin_read_select,
  input wire logic irq
);
  logic [7:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] cfg_q;
  logic [7:0] en_q;

  // shadow of config and enables, updated when the write completes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= 8'h00;
      data_q <= 8'h00;
      cfg_q <= 8'h00;
      en_q <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) addr_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) data_q <= s_axi_wdata[7:0];
      if ($rose(s_axi_bvalid) && addr_q == tt_pkg::OFF_CONFIG) cfg_q <= data_q;
      if ($rose(s_axi_bvalid) && addr_q == tt_pkg::OFF_FLAGS_ENABLES) en_q <= data_q & tt_pkg::ENABLE_MASK;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence s_cap_rise;
    cfg_q[1:0] == 2'h2 && cfg_q[6] && en_q[5] && $rose(capture_input_first);
  endsequence

  chk_wr_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  chk_b_single: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  chk_pin_select: assert property ($rose(s_axi_bvalid) && addr_q == tt_pkg::OFF_CONFIG
    |-> pin_read_select == data_q[7]) else $error("pin read select wrong");
  chk_unmapped_err: assert property ($rose(s_axi_bvalid) && addr_q > tt_pkg::OFF_IRQ_ENABLE
    |-> s_axi_bresp == tt_pkg::RESP_SLVERR) else $error("unmapped write not refused");
  chk_cap_irq: assert property (s_cap_rise |-> ##[1:3] irq)
    else $error("capture edge raised no interrupt");
  chk_irq_quiet: assert property (en_q == 8'h00 && $past(en_q) == 8'h00 |-> !irq)
    else $error("interrupt with all enables off");
endmodule // tt_timer_two_sva

bind tt_timer_two tt_timer_two_sva u_sva (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .capture_input_first, .pin_read_select, .irq);

/* verification/tt_pin_model.sv */
// behavioural model of the external capture and event pins
// assumes the bench requests pin levels just after a clock edge
`timescale 1ns/1ps
module tt_pin_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] level_req,
  output logic capture_input_first,
  output logic capture_input_second,
  output logic event_count_input
);
  // pins rest low during reset, then follow the request one edge later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {event_count_input, capture_input_second, capture_input_first} <= 3'h0;
    end else begin
      {event_count_input, capture_input_second, capture_input_first} <= level_req;
    end
  end
endmodule // tt_pin_model

/* verification/tb_timer_two_control_regs.sv */
// self-checking bench for the second timer control block
// assumes the pin model and the bound checker are compiled before it
`timescale 1ns/1ps
module tb_timer_two_control_regs;
  logic clk;
  logic reset_n;
  logic [tt_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [tt_pkg::DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pin_read_select, irq;
  logic capture_input_first, capture_input_second, event_count_input;
  logic [2:0] pin_req;
  logic [1:0] exp_b[$];
  logic [65:0] exp_r[$];
  int n_fail, tests_run, seed;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  tt_timer_two DUT (.clk, .reset_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capture_input_first, .capture_input_second,
    .event_count_input, .pin_read_select, .irq);

  tt_pin_model PIN (.clk, .reset_n, .level_req(pin_req), .capture_input_first, .capture_input_second,
    .event_count_input);

  // answers are matched against the oldest note as they appear
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) cmp_resp(exp_b.pop_front(), s_axi_bresp);
    if (s_axi_rvalid && s_axi_rready) cmp_read(exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
  end

  task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected bresp: expected %h seen %h", e, g);
    end
  endtask

  // note layout: mask, response, data; only masked data bits are compared
  task automatic cmp_read(input logic [65:0] e, input logic [33:0] g);
    tests_run++;
    if ((g & {2'h3, e[65:34]}) !== e[33:0]) begin
      n_fail++;
      $display("unexpected read: expected %h seen %h", e[33:0], g);
    end
  endtask

  task automatic cmp_bit(input string w, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %b seen %b", w, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic stop_hang();
    n_fail++;
    $display("unexpected wait: expected 1 seen 0");
    final_report();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 100) stop_hang();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [33:0] e, output logic [31:0] got);
    int n;
    exp_r.push_back({m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    got = s_axi_rdata;
    if (n == 100) stop_hang();
  endtask

  task automatic wait_irq(input int lim);
    int n;
    for (n = 0; n < lim && irq !== 1'b1; n++) @(posedge clk);
    if (n == lim) stop_hang();
  endtask

  initial begin
    logic [31:0] v, c1, c2;
    int k, e, lim;
    seed = 31;
    n_fail = 0;
    tests_run = 0;
    reset_n = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    pin_req = 3'h0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(tt_pkg::OFF_FLAGS_ENABLES, 32'hFFFFFFFF, {tt_pkg::RESP_OKAY, 32'h0}, v);
    rd(tt_pkg::OFF_CONFIG, 32'hFFFFFFFF, {tt_pkg::RESP_OKAY, 32'h0}, v);
    rd(8'h40, 32'hFFFFFFFF, {tt_pkg::RESP_SLVERR, 32'h0}, v);
    wr(8'h40, 32'h0, tt_pkg::RESP_SLVERR);
    $display("test reset_map done");
    for (k = 0; k < 4; k++) begin
      v = $random(seed);
      v[1:0] = k[1:0];
      wr(tt_pkg::OFF_CONFIG, v, tt_pkg::RESP_OKAY);
      rd(tt_pkg::OFF_CONFIG, 32'hFFFFFFFF, {tt_pkg::RESP_OKAY, 24'h0, v[7:0]}, c1);
      cmp_bit("pin_read_select", v[7], pin_read_select);
    end
    $display("test config done");
    for (k = 0; k < 8; k++) begin
      wr(tt_pkg::OFF_CONFIG, {24'h0, 3'h0, k[2:0], 1'b0, k[0]}, tt_pkg::RESP_OKAY);
      rd(tt_pkg::OFF_COUNT, 32'h0, {tt_pkg::RESP_OKAY, 32'h0}, c1);
      repeat (1024) @(posedge clk);
      rd(tt_pkg::OFF_COUNT, 32'h0, {tt_pkg::RESP_OKAY, 32'h0}, c2);
      e = int'(c2[15:0] - c1[15:0]);
      lim = 1026 >> k;
      cmp_bit("count step", 1'b1, e >= lim - 1 && e <= lim + 1);
    end
    $display("test prescale done");
    wr(tt_pkg::OFF_CONFIG, 32'h0, tt_pkg::RESP_OKAY);
    rd(tt_pkg::OFF_COUNT, 32'h0, {tt_pkg::RESP_OKAY, 32'h0}, c1);
    wr(tt_pkg::OFF_COMPARE_FIRST, {16'h0, c1[15:0] + 16'd300}, tt_pkg::RESP_OKAY);
    wr(tt_pkg::OFF_COMPARE_SECOND, {16'h0, c1[15:0] + 16'd600}, tt_pkg::RESP_OKAY);
    wr(tt_pkg::OFF_FLAGS_ENABLES, 32'h04, tt_pkg::RESP_OKAY);
    wait_irq(400);
    rd(tt_pkg::OFF_FLAGS_ENABLES, 32'h18, {tt_pkg::RESP_OKAY, 32'h08}, v);
    repeat (350) @(posedge clk);
    rd(tt_pkg::OFF_FLAGS_ENABLES, 32'h18, {tt_pkg::RESP_OKAY, 32'h18}, v);
    wr(tt_pkg::OFF_FLAGS_ENABLES, 32'h0, tt_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    cmp_bit("irq", 1'b0, irq);
    $display("test compare done");
    wr(tt_pkg::OFF_CONFIG, 32'h42, tt_pkg::RESP_OKAY);
    wr(tt_pkg::OFF_FLAGS_ENABLES, 32'h20, tt_pkg::RESP_OKAY);
    pin_req <= 3'h1;
    wait_irq(20);
    rd(tt_pkg::OFF_FLAGS_ENABLES, 32'hC0, {tt_pkg::RESP_OKAY, 32'h40}, v);
    wr(tt_pkg::OFF_CONFIG, 32'h02, tt_pkg::RESP_OKAY);
    wr(tt_pkg::OFF_FLAGS_ENABLES, 32'h20, tt_pkg::RESP_OKAY);
    pin_req <= 3'h3;
    repeat (8) @(posedge clk);
    rd(tt_pkg::OFF_FLAGS_ENABLES, 32'hC0, {tt_pkg::RESP_OKAY, 32'h00}, v);
    pin_req <= 3'h1;
    wait_irq(20);
    rd(tt_pkg::OFF_FLAGS_ENABLES, 32'hC0, {tt_pkg::RESP_OKAY, 32'h80}, v);
    wr(tt_pkg::OFF_FLAGS_ENABLES, 32'h0, tt_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    cmp_bit("irq", 1'b0, irq);
    $display("test capture done");
    // falling edges counted from a low pin, then rising from a high one: one of each
    for (k = 0; k < 2; k++) begin
      wr(tt_pkg::OFF_CONFIG, k ? 32'h23 : 32'h03, tt_pkg::RESP_OKAY);
      rd(tt_pkg::OFF_COUNT, 32'h0, {tt_pkg::RESP_OKAY, 32'h0}, c1);
      for (e = 0; e < 3; e++) begin
        pin_req[2] <= ~pin_req[2];
        repeat (4) @(posedge clk);
      end
      rd(tt_pkg::OFF_COUNT, 32'h0, {tt_pkg::RESP_OKAY, 32'h0}, c2);
      cmp_bit("event count", 1'b1, c2[15:0] - c1[15:0] == 16'h1);
    end
    $display("test event done");
    wr(tt_pkg::OFF_CONFIG, 32'h0, tt_pkg::RESP_OKAY);
    wr(tt_pkg::OFF_FLAGS_ENABLES, 32'h01, tt_pkg::RESP_OKAY);
    wait_irq(70000);
    rd(tt_pkg::OFF_IRQ_STATUS, 32'h02, {tt_pkg::RESP_OKAY, 32'h02}, v);
    wr(tt_pkg::OFF_IRQ_CLEAR, 32'h02, tt_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    cmp_bit("irq", 1'b0, irq);
    $display("test overflow done");
    final_report();
  end
endmodule // tb_timer_two_control_regs
